// ===== verilog/dbg_ext_top.sv
// APB-reached comparator B/C extension control of the bus-trace debug unit
// Operation
// - B direction enable includes read/write
// - B direction value: 0 write, 1 read
// - Full mode makes B use comparator A direction; C keeps its own
// - B page select must equal paged flag
// - Paged address is page:addr[13:0]
// - Full modes ignore B page, bit16
// - B bit16 sets expected address bit16
// - C direction enable includes read/write
// - C direction value: 0 write, 1 read
// - C page select must equal paged flag
// - C bit16 sets expected address bit16
// - End-trace reset keeps extension registers only while debug is enabled and begin is clear
// - Debug enable forced off while secured
module dbg_ext_top
  import dbg_ext_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System reset and security
  input wire logic sys_reset_req,
  input wire logic reset_by_end_trace,
  input wire logic secure,
  // Core bus
  input wire logic core_valid,
  input wire logic core_rw,
  input wire logic core_paged,
  input wire logic [2:0] core_page,
  input wire logic [15:0] core_addr,
  input wire logic core_linear,
  input wire logic [16:0] core_linear_ptr,
  // Qualified results
  output logic qual_b_q,
  output logic qual_c_q,
  output logic [16:0] addr17_q,
  output logic debug_unit_enable_q
);
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic [5:0] word_idx;
  logic setup_ph;
  logic access_ph;
  logic hit_a;
  logic hit_b;
  logic hit_c;
  logic hit_ctrl;
  logic hit_stat;
  logic mapped;
  logic wr_acc;

  assign word_idx = paddr[7:2];
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable && pready;
  assign hit_a = (word_idx == IDX_CMP_A_EXT);
  assign hit_b = (word_idx == IDX_CMP_B_EXT);
  assign hit_c = (word_idx == IDX_CMP_C_EXT);
  assign hit_ctrl = (word_idx == IDX_CTRL);
  assign hit_stat = (word_idx == IDX_STATUS);
  assign mapped = hit_a || hit_b || hit_c || hit_ctrl || hit_stat;
  assign wr_acc = access_ph && pwrite;

  // ----------------------------------------
  // Reset retention
  // ----------------------------------------
  logic begin_q;
  logic full_q;
  logic retain;
  logic soft_clr;

  assign retain = reset_by_end_trace && debug_unit_enable_q && !begin_q;
  assign soft_clr = sys_reset_req && !retain;

  // ----------------------------------------
  // Extension registers
  // ----------------------------------------
  logic [3:0] a_q;
  logic [3:0] b_q;
  logic [3:0] c_q;

  dbg_ext_reg u_reg_a (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_acc && hit_a),
    .wdata(pwdata[7:0]),
    .soft_clr(soft_clr),
    .fields_q(a_q)
  );

  // Only bits 7, 6, 5 and 0 are stored
  dbg_ext_reg u_reg_b (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_acc && hit_b),
    .wdata(pwdata[7:0]),
    .soft_clr(soft_clr),
    .fields_q(b_q)
  );

  dbg_ext_reg u_reg_c (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_acc && hit_c),
    .wdata(pwdata[7:0]),
    .soft_clr(soft_clr),
    .fields_q(c_q)
  );

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic en_d;
  logic begin_d;
  logic full_d;
  logic ctrl_wr;

  assign ctrl_wr = wr_acc && hit_ctrl;
  assign en_d = secure ? 1'b0 :
                soft_clr ? DBG_EN_RST :
                ctrl_wr ? pwdata[BIT_DBG_EN] : debug_unit_enable_q;
  assign begin_d = soft_clr ? BEGIN_RST :
                   ctrl_wr ? pwdata[BIT_BEGIN] : begin_q;
  assign full_d = soft_clr ? FULL_RST :
                  ctrl_wr ? pwdata[BIT_FULL] : full_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_unit_enable_q <= 1'b0;
      begin_q <= BEGIN_RST;
      full_q <= FULL_RST;
    end else begin
      debug_unit_enable_q <= en_d;
      begin_q <= begin_d;
      full_q <= full_d;
    end
  end

  // ----------------------------------------
  // Compared address
  // ----------------------------------------
  logic [16:0] addr17;

  assign addr17 = core_paged ? {core_page, core_addr[LOW_W-1:0]} :
                  core_linear ? core_linear_ptr : {1'b0, core_addr};

  // ----------------------------------------
  // Qualifiers
  // ----------------------------------------
  logic ok_b;
  logic ok_c;
  logic live;

  assign live = core_valid && debug_unit_enable_q;

  // Full mode swaps in comparator A direction
  dbg_cmp_qual u_qual_b (
    .dir_en(b_q[3]),
    .dir_val(b_q[2]),
    .page_sel(b_q[1]),
    .addr16_sel(b_q[0]),
    .full_mode(full_q),
    .a_dir_en(a_q[3]),
    .a_dir_val(a_q[2]),
    .core_valid(live),
    .core_rw(core_rw),
    .core_paged(core_paged),
    .core_addr16(addr17[16]),
    .qual_ok(ok_b)
  );

  dbg_cmp_qual u_qual_c (
    .dir_en(c_q[3]),
    .dir_val(c_q[2]),
    .page_sel(c_q[1]),
    .addr16_sel(c_q[0]),
    .full_mode(1'b0),
    .a_dir_en(1'b0),
    .a_dir_val(1'b0),
    .core_valid(live),
    .core_rw(core_rw),
    .core_paged(core_paged),
    .core_addr16(addr17[16]),
    .qual_ok(ok_c)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qual_b_q <= 1'b0;
      qual_c_q <= 1'b0;
      addr17_q <= 17'h00000;
    end else begin
      qual_b_q <= ok_b;
      qual_c_q <= ok_c;
      addr17_q <= addr17;
    end
  end

  // ----------------------------------------
  // Read data and bus answer
  // ----------------------------------------
  logic [7:0] rd_a;
  logic [7:0] rd_b;
  logic [7:0] rd_c;
  logic [7:0] rd_ctrl;
  logic [7:0] rd_stat;
  logic [7:0] rd_sel;

  assign rd_a = {a_q[3:1], 4'h0, a_q[0]};
  assign rd_b = {b_q[3:1], 4'h0, b_q[0]};
  assign rd_c = {c_q[3:1], 4'h0, c_q[0]};
  assign rd_ctrl = {debug_unit_enable_q, 4'h0, begin_q, 1'b0, full_q};
  assign rd_stat = {5'h00, secure, qual_c_q, qual_b_q};
  assign rd_sel = hit_a ? rd_a :
                  hit_b ? rd_b :
                  hit_c ? rd_c :
                  hit_ctrl ? rd_ctrl :
                  hit_stat ? rd_stat : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph && !mapped;
      prdata <= setup_ph ? {24'h000000, rd_sel} : 32'h00000000;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_b_dir_enable: assert property (
    (b_q[3] && !full_q && core_rw != b_q[2]) |=> !qual_b_q)
    else $error("B matched wrong direction");

  chk_b_dir_ignored: assert property (
    (!b_q[3] && !full_q && live && core_paged == b_q[1]
     && addr17[16] == b_q[0]) |=> qual_b_q)
    else $error("B direction value used while disabled");

  chk_full_a_dir: assert property (
    (full_q && a_q[3] && core_rw != a_q[2]) |=> !qual_b_q)
    else $error("Full mode ignored A direction");

  chk_b_page_qual: assert property (
    (!full_q && core_paged != b_q[1]) |=> !qual_b_q)
    else $error("B page select not honoured");

  chk_paged_addr: assert property (
    core_paged |=> addr17_q == {$past(core_page), $past(core_addr[13:0])})
    else $error("Paged address wrong");

  chk_full_ext_ignored: assert property (
    (full_q && live && !a_q[3]) |=> qual_b_q)
    else $error("Full mode used B page or bit16");

  chk_b_bit16: assert property (
    (!full_q && addr17[16] != b_q[0]) |=> !qual_b_q)
    else $error("B bit16 not honoured");

  chk_c_dir_enable: assert property (
    (c_q[3] && core_rw != c_q[2]) |=> !qual_c_q)
    else $error("C matched wrong direction");

  chk_c_dir_ignored: assert property (
    (!c_q[3] && live && core_paged == c_q[1]
     && addr17[16] == c_q[0]) |=> qual_c_q)
    else $error("C direction value used while disabled");

  chk_c_page_qual: assert property (
    (core_paged != c_q[1]) |=> !qual_c_q)
    else $error("C page select not honoured");

  chk_c_bit16: assert property (
    (addr17[16] != c_q[0]) |=> !qual_c_q)
    else $error("C bit16 not honoured");

  chk_end_trace_keep: assert property (
    (sys_reset_req && retain && !wr_acc) |=> $stable(b_q) && $stable(c_q))
    else $error("Extension lost on end-trace reset");

  chk_unused_bits: assert property (
    (pready && (hit_b || hit_c)) |-> prdata[4:1] == 4'h0)
    else $error("Unimplemented bits read nonzero");

  chk_secure_disable: assert property (
    secure |=> !debug_unit_enable_q)
    else $error("Debug enabled while secure");

  chk_b_write_match: assert property (
    (b_q[3] && !b_q[2] && !full_q && live && !core_rw && core_paged == b_q[1]
     && addr17[16] == b_q[0]) |=> qual_b_q)
    else $error("B missed a write cycle");

  chk_c_read_match: assert property (
    (c_q[3] && c_q[2] && live && core_rw && core_paged == c_q[1]
     && addr17[16] == c_q[0]) |=> qual_c_q)
    else $error("C missed a read cycle");

  chk_unused_write: assert property (
    (wr_acc && hit_b && !soft_clr) |=> b_q == {$past(pwdata[7:5]), $past(pwdata[0])})
    else $error("B write stored wrong bits");

  chk_full_a_dir_ok: assert property (
    (full_q && live && a_q[3] && core_rw == a_q[2]) |=> qual_b_q)
    else $error("Full mode rejected A direction match");

  chk_linear_addr: assert property (
    (!core_paged && core_linear) |=> addr17_q == $past(core_linear_ptr))
    else $error("Linear address wrong");

  chk_cpu_addr: assert property (
    (!core_paged && !core_linear) |=> addr17_q == {1'b0, $past(core_addr)})
    else $error("CPU address wrong");

  chk_clear_on_reset: assert property (
    (sys_reset_req && !retain) |=> b_q == EXT_RST && c_q == EXT_RST)
    else $error("Extension kept on plain reset");

  chk_qual_disabled: assert property (
    !live |=> !qual_b_q && !qual_c_q)
    else $error("Qualifier set while idle or disabled");

  cov_b_match: cover property (qual_b_q && b_q[3]);
  cov_c_paged: cover property (qual_c_q && c_q[1]);
  cov_retain: cover property (sys_reset_req && retain);
  cov_full_b: cover property (full_q && qual_b_q);
  cov_linear: cover property (live && core_linear && !core_paged);
endmodule

// ===== verilog/dbg_ext_pkg.sv
// Constants for the comparator extension block
package dbg_ext_pkg;
  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [5:0] IDX_CMP_A_EXT = 6'h08;
  localparam logic [5:0] IDX_CMP_B_EXT = 6'h09;
  localparam logic [5:0] IDX_CMP_C_EXT = 6'h0a;
  localparam logic [5:0] IDX_CTRL = 6'h0c;
  localparam logic [5:0] IDX_STATUS = 6'h0d;
  // ----------------------------------------
  // Extension register fields
  // ----------------------------------------
  localparam int BIT_DIR_EN = 7;
  localparam int BIT_DIR_VAL = 6;
  localparam int BIT_PAGE_SEL = 5;
  localparam int BIT_ADDR16 = 0;
  localparam logic [3:0] EXT_RST = 4'h0;
  // ----------------------------------------
  // Control and status fields
  // ----------------------------------------
  localparam int BIT_DBG_EN = 7;
  localparam int BIT_BEGIN = 2;
  localparam int BIT_FULL = 0;
  localparam logic DBG_EN_RST = 1'b1;
  localparam logic BEGIN_RST = 1'b0;
  localparam logic FULL_RST = 1'b0;
  localparam int BIT_QUAL_B = 0;
  localparam int BIT_QUAL_C = 1;
  localparam int BIT_SECURE = 2;
  // ----------------------------------------
  // Address layout
  // ----------------------------------------
  localparam int PAGE_W = 3;
  localparam int LOW_W = 14;
endpackage

// ===== verilog/dbg_ext_reg.sv
// One comparator extension register with end-trace retention
module dbg_ext_reg
  import dbg_ext_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  input wire logic soft_clr,
  // Stored fields {dir_en, dir_val, page_sel, addr16}
  output logic [3:0] fields_q
);
  logic [3:0] fields_d;

  assign fields_d = soft_clr ? EXT_RST :
                    wr_en ? {wdata[BIT_DIR_EN], wdata[BIT_DIR_VAL],
                             wdata[BIT_PAGE_SEL], wdata[BIT_ADDR16]} :
                    fields_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fields_q <= EXT_RST;
    end else begin
      fields_q <= fields_d;
    end
  end
endmodule

// ===== verilog/dbg_cmp_qual.sv
// Direction, page and bit-16 qualifier for one comparator
module dbg_cmp_qual (
  // Comparator settings
  input wire logic dir_en,
  input wire logic dir_val,
  input wire logic page_sel,
  input wire logic addr16_sel,
  // Full-mode override
  input wire logic full_mode,
  input wire logic a_dir_en,
  input wire logic a_dir_val,
  // Core bus
  input wire logic core_valid,
  input wire logic core_rw,
  input wire logic core_paged,
  input wire logic core_addr16,
  // Result
  output logic qual_ok
);
  logic use_en;
  logic use_val;
  logic dir_ok;
  logic ext_ok;

  assign use_en = full_mode ? a_dir_en : dir_en;
  assign use_val = full_mode ? a_dir_val : dir_val;
  assign dir_ok = !use_en || (use_val == core_rw);
  assign ext_ok = full_mode ||
                  ((page_sel == core_paged) && (addr16_sel == core_addr16));
  assign qual_ok = core_valid && dir_ok && ext_ok;
endmodule

// ===== tb/core_bus_model.sv
// Core bus model issuing one address cycle at a time
module core_bus_model (
  // Clock
  input wire logic pclk,
  // Core bus
  output logic core_valid,
  output logic core_rw,
  output logic core_paged,
  output logic [2:0] core_page,
  output logic [15:0] core_addr,
  output logic core_linear,
  output logic [16:0] core_linear_ptr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    core_valid = 1'b0;
    core_rw = 1'b0;
    core_paged = 1'b0;
    core_page = 3'h0;
    core_addr = 16'h0000;
    core_linear = 1'b0;
    core_linear_ptr = 17'h00000;
  end
  // One valid cycle; afterwards address lines carry junk
  task automatic cyc(input logic rw, input logic pg, input logic [2:0] page,
      input logic [15:0] a, input logic lin, input logic [16:0] p);
    @(posedge pclk);
    core_valid <= 1'b1;
    core_rw <= rw;
    core_paged <= pg;
    core_page <= page;
    core_addr <= a;
    core_linear <= lin;
    core_linear_ptr <= p;
    @(posedge pclk);
    core_valid <= 1'b0;
    core_page <= ~page;
    core_addr <= ~a;
    core_linear_ptr <= ~p;
  endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the comparator extension block
module testbench
  import dbg_ext_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] AA = {IDX_CMP_A_EXT, 2'b00};
  localparam logic [7:0] AB = {IDX_CMP_B_EXT, 2'b00};
  localparam logic [7:0] AC = {IDX_CMP_C_EXT, 2'b00};
  localparam logic [7:0] ACT = {IDX_CTRL, 2'b00};
  localparam logic [7:0] AS = {IDX_STATUS, 2'b00};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, sys_reset_req = 0, reset_by_end_trace = 0, secure = 0;
  logic core_valid, core_rw, core_paged, core_linear;
  logic qual_b_q, qual_c_q, debug_unit_enable_q;
  logic [2:0] core_page;
  logic [15:0] core_addr;
  logic [16:0] core_linear_ptr, addr17_q;
  int fail_count = 0, n_compared = 0;
  always #2.5 pclk = ~pclk;
  dbg_ext_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sys_reset_req, .reset_by_end_trace, .secure,
    .core_valid, .core_rw, .core_paged, .core_page, .core_addr, .core_linear,
    .core_linear_ptr, .qual_b_q, .qual_c_q, .addr17_q, .debug_unit_enable_q);
  core_bus_model cbm (.pclk, .core_valid, .core_rw, .core_paged, .core_page,
    .core_addr, .core_linear, .core_linear_ptr);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      fail_count++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic sreset(input logic et);
    @(posedge pclk);
    sys_reset_req <= 1'b1;
    reset_by_end_trace <= et;
    @(posedge pclk);
    sys_reset_req <= 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    apb(0, AB, 0);
    chk(rd, 0);
    apb(1, AB, 32'hffff_ffff);
    apb(0, AB, 0);
    chk(rd, 32'he1);
    chk(err, 0);
    apb(1, AC, 32'h1e);
    apb(0, AC, 0);
    chk(rd, 0);
    apb(0, 8'h3c, 0);
    chk(err, 1);
    $display("test regs done");
  endtask
  task automatic t_secure();
    chk(debug_unit_enable_q, 0);
    secure <= 1'b1;
    apb(1, ACT, 32'h80);
    apb(0, AS, 0);
    chk(rd, 32'h4);
    #1;
    chk(debug_unit_enable_q, 0);
    @(posedge pclk);
    secure <= 1'b0;
    apb(1, ACT, 32'h80);
    #1;
    chk(debug_unit_enable_q, 1);
    $display("test secure done");
  endtask
  task automatic t_dir();
    logic [2:0] i;
    logic ex;
    for (int k = 0; k < 8; k++) begin
      i = k[2:0];
      apb(1, AB, {24'h0, i[2:1], 6'h0});
      apb(1, AC, {24'h0, i[2:1], 6'h0});
      cbm.cyc(i[0], 0, 0, 16'h1234, 0, 0);
      #1;
      ex = !i[2] || (i[1] == i[0]);
      chk(qual_b_q, ex);
      chk(qual_c_q, ex);
    end
    $display("test direction done");
  endtask
  task automatic t_page();
    logic [3:0] i;
    for (int k = 0; k < 16; k++) begin
      i = k[3:0];
      apb(1, AB, {24'h0, 2'b00, i[1], 4'h0, i[0]});
      apb(1, AC, {24'h0, 2'b00, ~i[1], 4'h0, i[0]});
      cbm.cyc(0, i[3], {i[2], 2'b01}, 16'hc567, !i[3], {i[2], 16'h9abc});
      #1;
      chk(addr17_q, i[3] ? {i[2], 2'b01, 14'h0567} : {i[2], 16'h9abc});
      chk(qual_b_q, i[1] == i[3] && i[0] == i[2]);
      chk(qual_c_q, i[1] != i[3] && i[0] == i[2]);
    end
    cbm.cyc(0, 0, 0, 16'hc567, 0, 0);
    #1;
    chk(addr17_q, 17'h0c567);
    $display("test page done");
  endtask
  task automatic t_full();
    apb(1, ACT, 32'h81);
    apb(0, ACT, 0);
    chk(rd, 32'h81);
    apb(1, AA, 32'hc0);
    apb(1, AB, 32'ha1);
    apb(1, AC, 32'h00);
    cbm.cyc(0, 0, 0, 16'h0040, 0, 0);
    #1;
    chk(qual_b_q, 0);
    cbm.cyc(1, 0, 0, 16'h0040, 0, 0);
    #1;
    chk(qual_b_q, 1);
    chk(qual_c_q, 1);
    apb(1, ACT, 32'h80);
    $display("test full done");
  endtask
  task automatic t_keep();
    apb(1, AB, 32'he1);
    apb(1, AC, 32'h61);
    sreset(1);
    apb(0, AB, 0);
    chk(rd, 32'he1);
    apb(0, AC, 0);
    chk(rd, 32'h61);
    sreset(0);
    apb(0, AB, 0);
    chk(rd, 0);
    chk(debug_unit_enable_q, 1);
    apb(1, AB, 32'he1);
    apb(1, ACT, 32'h00);
    sreset(1);
    apb(0, AB, 0);
    chk(rd, 0);
    chk(debug_unit_enable_q, 1);
    apb(1, AB, 32'he1);
    apb(1, ACT, 32'h84);
    sreset(1);
    apb(0, AB, 0);
    chk(rd, 0);
    apb(0, ACT, 0);
    chk(rd, 32'h80);
    apb(1, AC, 32'h61);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, AC, 0);
    chk(rd, 0);
    #1;
    chk(debug_unit_enable_q, 0);
    $display("test keep done");
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_secure();
    t_dir();
    t_page();
    t_full();
    t_keep();
    end_sim();
  end
endmodule
